// >>> inc/pdn_map.svh
// Offsets, field positions, reset values and timing counts of the delimiter
// and link negotiation block. Assumes a 200 MHz pclk and an APB register bus.
//
// Operation
// - 100M transmit replaces first two symbols with J/K.
// - Receive tests ten-bit windows as two symbols.
// - Idle receiver reports no valid data.
// - Idle J/K starts reception, passes two 5s.
// - Other active window raises false carrier, bad start.
// - After false carrier, wait for two idles.
// - Other quiet window is dropped, stay idle.
// - 10M squelch qualification asserts carrier sense.
// - 100M transmit appends T/R after last data.
// - T/R ends packet, passes two idles.
// - Two idles mid-packet flag error on first.
// - Premature end sets bad end-delimiter status.
// - 10M transmit emits start-of-idle pulse after enable.
// - 10M missing transitions end reception, report idle.
// - Choose link integrity or negotiation for link.
// - 10M link pass from normal link pulses.
// - 100M link pass from squelch and descrambler lock.
// - Negotiation exchanges sixteen-bit words over pulse bursts.
// - Start on enable, link fail or reset.
// - Plain partner signal selects matching mode.
// - Advertise register, store received remote capabilities.
// - Resolve priority, set speed, duplex, link check.
// - Negotiation needs both enable bits set.
// - On enable, silence transmitter, then restart.
`ifndef PDN_MAP_SVH
`define PDN_MAP_SVH

`define PDN_OFS_CTRL        12'h000
`define PDN_OFS_ADV         12'h004
`define PDN_OFS_REMOTE      12'h008
`define PDN_OFS_STATUS      12'h00C

`define PDN_CTRL_MAC_AN     0
`define PDN_CTRL_PHY_AN     1
`define PDN_CTRL_AN_RESET   2
`define PDN_CTRL_SPEED100   3
`define PDN_CTRL_DUPLEX     4
`define PDN_CTRL_RESET      5'h00

`define PDN_ST_LINK         0
`define PDN_ST_SPEED100     1
`define PDN_ST_DUPLEX       2
`define PDN_ST_AN_ACK       3
`define PDN_ST_BAD_SSD      4
`define PDN_ST_BAD_ESD      5

`define PDN_ADV_RESET       16'h01E1
`define PDN_ABL_100FD       8
`define PDN_ABL_100HD       7
`define PDN_ABL_10FD        6
`define PDN_ABL_10HD        5

`define PDN_SYM_J           5'h18
`define PDN_SYM_K           5'h11
`define PDN_SYM_T           5'h0D
`define PDN_SYM_R           5'h07
`define PDN_SYM_I           5'h1F
`define PDN_SYM_DATA5       5'h0B

`define PDN_CLK_MHZ         200
`define PDN_HALT_MS         1200
`define PDN_HALT_CYC        (`PDN_HALT_MS * 1000 * `PDN_CLK_MHZ)
`define PDN_NLP_LOSS_MS     150
`define PDN_NLP_LOSS_CYC    (`PDN_NLP_LOSS_MS * 1000 * `PDN_CLK_MHZ)

`endif

// >>> inc/pdn_pkg.sv
// Types shared by the delimiter and link negotiation block.
// Assumes nothing of its surroundings.
package pdn_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_RECV  = 2'b01,
    RX_FALSE = 2'b10
  } pdn_rx_state_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_K    = 2'b01,
    TX_DATA = 2'b10,
    TX_R    = 2'b11
  } pdn_tx_state_type;

  typedef enum logic [2:0] {
    AN_OFF    = 3'b000,
    AN_HALT   = 3'b001,
    AN_DETECT = 3'b010,
    AN_XCHG   = 3'b011,
    AN_DONE   = 3'b100
  } pdn_an_state_type;

  // Receive symbol towards the MAC side.
  typedef struct packed {
    logic       valid;
    logic       dv;
    logic       er;
    logic       false_carrier;
    logic [4:0] code;
  } pdn_rx_type;

endpackage

// >>> verilog/pdn_top.sv
// Delimiter insertion and detection, 10M packet framing and link negotiation.
// Assumes 4B5B encode/decode, scrambling, pulse generation and squelch sit outside.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "pdn_map.svh"

module pdn_top #(
  parameter int unsigned HALT_CYC     = `PDN_HALT_CYC,
  parameter int unsigned NLP_LOSS_CYC = `PDN_NLP_LOSS_CYC
) (
  // Clock and reset
  input  wire  logic              pclk,
  input  wire  logic              presetn,
  // APB slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [11:0]       paddr,
  input  wire  logic [31:0]       pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // 100M receive code bits from the descrambler
  input  wire  logic              rx_bit,
  input  wire  logic              rx_bit_valid,
  input  wire  logic              descr_locked,
  output pdn_pkg::pdn_rx_type     rx_out,
  // 100M transmit symbols from the encoder
  input  wire  logic              tx_en,
  input  wire  logic [4:0]        tx_code_in,
  input  wire  logic              tx_sym_strobe,
  output logic [4:0]              tx_code,
  // 10M framing
  input  wire  logic              squelch_pin,
  input  wire  logic              soi_detect,
  input  wire  logic              nlp_seen,
  output logic                    crs,
  output logic                    tx_soi,
  // Fast link pulse words
  input  wire  logic              flp_detect,
  input  wire  logic              flp_word_valid,
  input  wire  logic [15:0]       flp_word,
  output logic [15:0]             flp_tx_word,
  output logic                    flp_tx_en,
  output logic                    tx_halt,
  // Link state
  output logic                    link_pass,
  output logic                    speed100,
  output logic                    full_duplex
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic split_zeros(input logic [9:0] w);
    logic seen;
    logic gap;
    logic hit;
    seen = 1'b0;
    gap  = 1'b0;
    hit  = 1'b0;
    for (int i = 9; i >= 0; i--)
    begin
      if (!w[i])
      begin
        if (seen && gap)
          hit = 1'b1;
        seen = 1'b1;
        gap  = 1'b0;
      end
      else if (seen)
        gap = 1'b1;
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Squelch comes from the analog side and is filtered by three flops.
  logic       sq1_q;
  logic       sq2_q;
  logic       sq3_q;
  logic       squelch_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sq1_q     <= 1'b0;
      sq2_q     <= 1'b0;
      sq3_q     <= 1'b0;
      squelch_q <= 1'b0;
    end
    else
    begin
      sq1_q <= squelch_pin;
      sq2_q <= sq1_q;
      sq3_q <= sq2_q;
      if (sq2_q == sq3_q)
        squelch_q <= sq3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0]  ctrl_q;
  logic [15:0] adv_q;
  logic [15:0] remote_q;
  logic        bad_ssd_q;
  logic        bad_esd_q;
  logic        an_ack_q;
  logic        an_reset_q;
  logic        mapped;
  logic        wr_acc;
  logic [31:0] rd_val;
  logic        set_ssd;
  logic        set_esd;

  assign mapped = (paddr == `PDN_OFS_CTRL) || (paddr == `PDN_OFS_ADV) ||
                  (paddr == `PDN_OFS_REMOTE) || (paddr == `PDN_OFS_STATUS);
  assign wr_acc = psel && penable && pready && pwrite && mapped;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `PDN_OFS_CTRL:   rd_val = {27'h0, ctrl_q};
      `PDN_OFS_ADV:    rd_val = {16'h0, adv_q};
      `PDN_OFS_REMOTE: rd_val = {16'h0, remote_q};
      `PDN_OFS_STATUS: rd_val = {26'h0, bad_esd_q, bad_ssd_q, an_ack_q,
                                 full_duplex, speed100, link_pass};
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // Zero wait states: pready rises in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= `PDN_CTRL_RESET;
      adv_q      <= `PDN_ADV_RESET;
      an_reset_q <= 1'b0;
    end
    else
    begin
      an_reset_q <= wr_acc && (paddr == `PDN_OFS_CTRL) && pwdata[`PDN_CTRL_AN_RESET];
      if (wr_acc && (paddr == `PDN_OFS_CTRL))
        ctrl_q <= {pwdata[4:3], 1'b0, pwdata[1:0]};
      if (wr_acc && (paddr == `PDN_OFS_ADV))
        adv_q <= pwdata[15:0];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bad_ssd_q <= 1'b0;
      bad_esd_q <= 1'b0;
    end
    else
    begin
      if (set_ssd)
        bad_ssd_q <= 1'b1;
      else if (wr_acc && (paddr == `PDN_OFS_STATUS) && pwdata[`PDN_ST_BAD_SSD])
        bad_ssd_q <= 1'b0;
      if (set_esd)
        bad_esd_q <= 1'b1;
      else if (wr_acc && (paddr == `PDN_OFS_STATUS) && pwdata[`PDN_ST_BAD_ESD])
        bad_esd_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pdn_pkg::pdn_rx_state_type rx_state_q;
  logic [9:0] win_q;
  logic [9:0] win;
  logic [2:0] bit_cnt_q;
  logic       first_q;
  logic       second_q;
  logic [4:0] second_code_q;
  logic       pkt_end;

  assign win = {win_q[8:0], rx_bit};
  // A closed packet leaves idles behind, so its delimiter bits cannot fake a carrier.
  assign pkt_end = speed100 && (rx_state_q == pdn_pkg::RX_RECV) && (bit_cnt_q == 3'h4) &&
                   (win == {`PDN_SYM_T, `PDN_SYM_R} || win == {`PDN_SYM_I, `PDN_SYM_I});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_q <= 10'h000;
    else if (rx_bit_valid)
      win_q <= pkt_end ? {`PDN_SYM_I, `PDN_SYM_I} : win;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q    <= pdn_pkg::RX_IDLE;
      bit_cnt_q     <= 3'h0;
      first_q       <= 1'b0;
      second_q      <= 1'b0;
      second_code_q <= 5'h00;
      rx_out        <= '0;
      set_ssd       <= 1'b0;
      set_esd       <= 1'b0;
    end
    else
    begin
      rx_out.valid <= 1'b0;
      set_ssd      <= 1'b0;
      set_esd      <= 1'b0;
      second_q     <= 1'b0;
      if (second_q)
      begin
        rx_out.valid <= 1'b1;
        rx_out.code  <= second_code_q;
        rx_out.er    <= 1'b0;
      end
      if (rx_bit_valid && speed100)
      begin
        unique case (rx_state_q)
          pdn_pkg::RX_IDLE:
          begin
            rx_out.dv <= 1'b0;
            rx_out.er <= 1'b0;
            rx_out.false_carrier <= 1'b0;
            if (win == {`PDN_SYM_J, `PDN_SYM_K})
            begin
              rx_state_q    <= pdn_pkg::RX_RECV;
              bit_cnt_q     <= 3'h0;
              first_q       <= 1'b1;
              rx_out.dv     <= 1'b1;
            end
            // Judged once the first zero is oldest, so a J/K still arriving is not cut short.
            else if (!win[9] && split_zeros(win))
            begin
              rx_state_q           <= pdn_pkg::RX_FALSE;
              rx_out.er            <= 1'b1;
              rx_out.false_carrier <= 1'b1;
              set_ssd              <= 1'b1;
            end
          end
          pdn_pkg::RX_FALSE:
          begin
            if (win == {`PDN_SYM_I, `PDN_SYM_I})
            begin
              rx_state_q           <= pdn_pkg::RX_IDLE;
              rx_out.er            <= 1'b0;
              rx_out.false_carrier <= 1'b0;
            end
          end
          pdn_pkg::RX_RECV:
          begin
            bit_cnt_q <= (bit_cnt_q == 3'h4) ? 3'h0 : bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h4)
            begin
              // The older symbol is emitted one symbol late so T/R is seen whole.
              rx_out.valid <= 1'b1;
              first_q      <= 1'b0;
              if (win == {`PDN_SYM_T, `PDN_SYM_R})
              begin
                rx_out.code   <= `PDN_SYM_I;
                rx_out.er     <= 1'b0;
                second_q      <= 1'b1;
                second_code_q <= `PDN_SYM_I;
                rx_state_q    <= pdn_pkg::RX_IDLE;
              end
              else if (win == {`PDN_SYM_I, `PDN_SYM_I})
              begin
                rx_out.code <= `PDN_SYM_I;
                rx_out.er   <= 1'b1;
                set_esd     <= 1'b1;
                rx_state_q  <= pdn_pkg::RX_IDLE;
              end
              else
              begin
                // K slot also passes as 5
                rx_out.code <= first_q ? `PDN_SYM_DATA5 : win[9:5];
                rx_out.er   <= 1'b0;
              end
            end
          end
          default:
            rx_state_q <= pdn_pkg::RX_IDLE;
        endcase
        if (rx_state_q == pdn_pkg::RX_IDLE && win == {`PDN_SYM_J, `PDN_SYM_K})
        begin
          rx_out.valid <= 1'b1;
          rx_out.code  <= `PDN_SYM_DATA5;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pdn_pkg::pdn_tx_state_type tx_state_q;
  logic tx_en_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_q <= pdn_pkg::TX_IDLE;
      tx_code    <= `PDN_SYM_I;
    end
    else if (tx_halt)
    begin
      tx_state_q <= pdn_pkg::TX_IDLE;
      tx_code    <= `PDN_SYM_I;
    end
    else if (tx_sym_strobe && speed100)
    begin
      unique case (tx_state_q)
        pdn_pkg::TX_IDLE:
        begin
          tx_code    <= tx_en ? `PDN_SYM_J : `PDN_SYM_I;
          tx_state_q <= tx_en ? pdn_pkg::TX_K : pdn_pkg::TX_IDLE;
        end
        pdn_pkg::TX_K:
        begin
          tx_code    <= `PDN_SYM_K;
          tx_state_q <= pdn_pkg::TX_DATA;
        end
        pdn_pkg::TX_DATA:
        begin
          tx_code    <= tx_en ? tx_code_in : `PDN_SYM_T;
          tx_state_q <= tx_en ? pdn_pkg::TX_DATA : pdn_pkg::TX_R;
        end
        pdn_pkg::TX_R:
        begin
          tx_code    <= `PDN_SYM_R;
          tx_state_q <= pdn_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // 10M framing on the MII carrier sense and the transmit end pulse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_en_q <= 1'b0;
      tx_soi  <= 1'b0;
      crs     <= 1'b0;
    end
    else
    begin
      tx_en_q <= tx_en;
      tx_soi  <= !speed100 && !tx_halt && tx_en_q && !tx_en;
      if (speed100)
        crs <= (rx_state_q == pdn_pkg::RX_RECV);
      else if (soi_detect)
        crs <= 1'b0;
      else if (squelch_q)
        crs <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pdn_pkg::pdn_an_state_type an_state_q;
  logic [27:0] halt_cnt_q;
  logic [27:0] nlp_cnt_q;
  logic        nlp_ok_q;
  logic        an_on;
  logic        an_on_q;
  logic        link100;
  logic        link_sel;
  logic [15:0] common;

  assign an_on   = ctrl_q[`PDN_CTRL_MAC_AN] && ctrl_q[`PDN_CTRL_PHY_AN];
  assign link100 = squelch_q && descr_locked;
  assign link_sel = speed100 ? link100 : nlp_ok_q;
  assign common  = adv_q & remote_q;

  // normal link pulses keep 10M link alive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nlp_cnt_q <= 28'h0000000;
      nlp_ok_q  <= 1'b0;
    end
    else if (nlp_seen)
    begin
      nlp_cnt_q <= 28'h0000000;
      nlp_ok_q  <= 1'b1;
    end
    else if (nlp_cnt_q == NLP_LOSS_CYC[27:0] - 28'h1)
      nlp_ok_q <= 1'b0;
    else
      nlp_cnt_q <= nlp_cnt_q + 28'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      an_state_q  <= pdn_pkg::AN_OFF;
      an_on_q     <= 1'b0;
      halt_cnt_q  <= 28'h0000000;
      remote_q    <= 16'h0000;
      an_ack_q    <= 1'b0;
      tx_halt     <= 1'b0;
      flp_tx_en   <= 1'b0;
      flp_tx_word <= 16'h0000;
      link_pass   <= 1'b0;
      speed100    <= 1'b0;
      full_duplex <= 1'b0;
    end
    else
    begin
      an_on_q <= an_on;
      // forced mode uses plain link integrity
      if (!an_on)
      begin
        an_state_q  <= pdn_pkg::AN_OFF;
        tx_halt     <= 1'b0;
        flp_tx_en   <= 1'b0;
        an_ack_q    <= 1'b0;
        speed100    <= ctrl_q[`PDN_CTRL_SPEED100];
        full_duplex <= ctrl_q[`PDN_CTRL_DUPLEX];
        link_pass   <= link_sel;
      end
      else if (!an_on_q || an_reset_q)
      begin
        an_state_q <= pdn_pkg::AN_HALT;
        halt_cnt_q <= 28'h0000000;
        tx_halt    <= 1'b1;
        flp_tx_en  <= 1'b0;
        link_pass  <= 1'b0;
        an_ack_q   <= 1'b0;
      end
      else
      begin
        unique case (an_state_q)
          pdn_pkg::AN_OFF:
            an_state_q <= pdn_pkg::AN_HALT;
          pdn_pkg::AN_HALT:
          begin
            halt_cnt_q <= halt_cnt_q + 28'h1;
            if (halt_cnt_q == HALT_CYC[27:0] - 28'h1)
            begin
              tx_halt    <= 1'b0;
              an_state_q <= pdn_pkg::AN_DETECT;
            end
          end
          pdn_pkg::AN_DETECT:
          begin
            if (flp_detect)
            begin
              flp_tx_word <= adv_q;
              flp_tx_en   <= 1'b1;
              an_state_q  <= pdn_pkg::AN_XCHG;
            end
            else if (link100)
            begin
              speed100    <= 1'b1;
              full_duplex <= 1'b0;
              link_pass   <= 1'b1;
              an_state_q  <= pdn_pkg::AN_DONE;
            end
            else if (nlp_ok_q)
            begin
              speed100    <= 1'b0;
              full_duplex <= 1'b0;
              link_pass   <= 1'b1;
              an_state_q  <= pdn_pkg::AN_DONE;
            end
          end
          pdn_pkg::AN_XCHG:
          begin
            if (flp_word_valid)
            begin
              remote_q   <= flp_word;
              an_state_q <= pdn_pkg::AN_DONE;
              an_ack_q   <= 1'b1;
              flp_tx_en  <= 1'b0;
              if (adv_q[`PDN_ABL_100FD] && flp_word[`PDN_ABL_100FD])
                {speed100, full_duplex} <= 2'b11;
              else if (adv_q[`PDN_ABL_100HD] && flp_word[`PDN_ABL_100HD])
                {speed100, full_duplex} <= 2'b10;
              else if (adv_q[`PDN_ABL_10FD] && flp_word[`PDN_ABL_10FD])
                {speed100, full_duplex} <= 2'b01;
              else
                {speed100, full_duplex} <= 2'b00;
            end
          end
          pdn_pkg::AN_DONE:
          begin
            link_pass <= link_sel;
            if (!link_sel && link_pass)
            begin
              an_state_q <= pdn_pkg::AN_DETECT;
              an_ack_q   <= 1'b0;
            end
          end
          default:
            an_state_q <= pdn_pkg::AN_OFF;
        endcase
      end
    end
  end

endmodule // pdn_top

// >>> dv/pdn_top_properties.sv
// Concurrent checks of the delimiter and link negotiation block.
// Assumes it is bound into pdn_top and sees the pclk domain only.
`timescale 1ns/100ps
module pdn_top_properties (
  // Clock and bus
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic               pready,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  // Line side
  input wire logic               rx_bit,
  input wire logic               rx_bit_valid,
  input wire pdn_pkg::pdn_rx_type rx_out,
  input wire logic               tx_en,
  input wire logic               soi_detect,
  input wire logic               crs,
  input wire logic               tx_soi,
  input wire logic               tx_halt,
  input wire logic               speed100,
  input wire logic               full_duplex
);
  logic [8:0] hist_q;
  logic [9:0] win;
  ////////////////////////////////////////
  // The window follows the decoder's own bits, except that the decoder loads idles at a packet end, so checks can key on it.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hist_q <= 9'h000;
    else if (rx_bit_valid)
      hist_q <= {hist_q[7:0], rx_bit};
  assign win = {hist_q, rx_bit};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  AST_JK_START: assert property (
    speed100 && rx_bit_valid && win == 10'h311 && !rx_out.dv && !rx_out.er
    |=> rx_out.valid && rx_out.dv && rx_out.code == 5'h0B) else $error("start delimiter missed");
  AST_FC_FLAG: assert property (
    $rose(rx_out.false_carrier) |-> rx_out.er && !rx_out.dv) else $error("false carrier flags wrong");
  AST_FC_HOLD: assert property (
    rx_out.false_carrier && !(rx_bit_valid && win == 10'h3FF) |=> rx_out.false_carrier)
    else $error("false carrier left early");
  AST_TR_END: assert property (
    rx_out.dv && rx_bit_valid && win == 10'h1A7 |=> rx_out.valid && rx_out.code == 5'h1F
    ##1 rx_out.valid && rx_out.code == 5'h1F) else $error("end delimiter not replaced");
  AST_PREMATURE: assert property (
    rx_out.dv && rx_bit_valid && win == 10'h3FF |=> rx_out.valid && rx_out.er)
    else $error("premature end not flagged");
  AST_SOI_TX: assert property (
    !speed100 && !tx_halt && $fell(tx_en) |-> ##[1:2] tx_soi) else $error("no start of idle pulse");
  AST_SOI_RX: assert property (
    !speed100 && soi_detect |=> !crs) else $error("carrier kept after start of idle");
  AST_HALT: assert property (
    psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'b11
    |-> ##[1:2] tx_halt) else $error("no transmit halt on enable");
  cover property (rx_out.valid && rx_out.dv);
  cover property (rx_out.false_carrier);
  cover property ($rose(full_duplex));
endmodule // pdn_top_properties

bind pdn_top pdn_top_properties chk_u (.*);

// >>> dv/pdn_partner.sv
// Remote link partner: serial code bits and fast link pulse words.
// Assumes its tasks are called from the bench in the pclk domain.
`timescale 1ns/100ps
module pdn_partner (
  // Clock
  input  wire logic        pclk,
  // Towards the block
  output logic             rx_bit,
  output logic             rx_bit_valid,
  output logic             flp_detect,
  output logic             flp_word_valid,
  output logic [15:0]      flp_word
);
  logic bit_q;
  logic tog_q;
  // Outside a frame the bit line wanders, so a stale bit is never reused.
  assign rx_bit = rx_bit_valid ? bit_q : tog_q;
  initial
  begin
    tog_q = 1'b0;
    bit_q = 1'b0;
    rx_bit_valid = 1'b0;
    flp_detect = 1'b0;
    flp_word_valid = 1'b0;
    flp_word = 16'h0000;
  end
  always @(posedge pclk)
    tog_q <= ~tog_q;
  // symbols go out most significant bit first
  task automatic send(input logic [4:0] s);
    for (int i = 4; i >= 0; i--)
    begin
      @(posedge pclk);
      bit_q <= s[i];
      rx_bit_valid <= 1'b1;
    end
  endtask
  task automatic quiet();
    @(posedge pclk);
    rx_bit_valid <= 1'b0;
  endtask
  task automatic flp(input logic [15:0] w);
    @(posedge pclk);
    flp_detect <= 1'b1;
    repeat (3) @(posedge pclk);
    flp_word <= w;
    flp_word_valid <= 1'b1;
    @(posedge pclk);
    flp_word_valid <= 1'b0;
    flp_word <= ~w;
  endtask
endmodule // pdn_partner

// >>> dv/pdn_top_tb_top.sv
// Self-checking bench of the delimiter and link negotiation block.
// Assumes pdn_top, the partner model and the bound checker are compiled.
`timescale 1ns/100ps
module pdn_top_tb_top;
  localparam logic [4:0] S_J = 5'h18, S_K = 5'h11, S_T = 5'h0D, S_R = 5'h07, S_I = 5'h1F, S_5 = 5'h0B;
  // Data codes chosen so no delimiter can appear across symbol borders.
  localparam logic [4:0] TBL [4] = '{5'h1E, 5'h1D, 5'h1B, 5'h17};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, rx_bit, rx_bit_valid, descr_locked = 1'b0, tx_en = 1'b0;
  logic [4:0]  tx_code_in = 5'h00, tx_code, d;
  logic        tx_sym_strobe = 1'b0, squelch_pin = 1'b0, soi_detect = 1'b0, nlp_seen = 1'b0;
  logic        flp_detect, flp_word_valid, crs, tx_soi, flp_tx_en, tx_halt, link_pass, speed100, full_duplex;
  logic [15:0] flp_word, flp_tx_word;
  pdn_pkg::pdn_rx_type rx_out;
  logic [4:0]  rq[$];
  int          mismatches = 0, n_checks = 0, cyc = 0;
  pdn_top #(.HALT_CYC(20), .NLP_LOSS_CYC(50)) dut_u (.*);
  pdn_partner prt_u (.*);
  ////////////////////////////////////////
  initial
    forever #2.5 pclk = ~pclk;
  always @(posedge pclk)
    if (++cyc > 20000)
    begin
      mismatches++;
      summarize();
    end
  always @(negedge pclk)
    if (rx_out.valid === 1'b1 && rq.size() > 0)
      check(32'(rx_out.code), 32'(rq.pop_front()), "rx");
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(rd_q & m, x, "reg");
  endtask
  task automatic wt(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(posedge pclk);
    check(32'(s), 32'(v), "wait");
  endtask
  task automatic stx(input logic [4:0] c, input logic [4:0] x);
    @(posedge pclk);
    tx_code_in <= c;
    tx_sym_strobe <= 1'b1;
    @(posedge pclk);
    tx_sym_strobe <= 1'b0;
    @(negedge pclk);
    check(32'(tx_code), 32'(x), "tx");
  endtask
  task automatic pkt(input int n, input logic good);
    prt_u.send(S_I);
    prt_u.send(S_I);
    rq.push_back(S_5);
    rq.push_back(S_5);
    prt_u.send(S_J);
    prt_u.send(S_K);
    for (int i = 0; i <= n; i++)
    begin
      d = (i == n) ? TBL[0] : TBL[$urandom_range(3)];
      rq.push_back(d);
      prt_u.send(d);
    end
    if (good)
    begin
      rq.push_back(S_I);
      rq.push_back(S_I);
      prt_u.send(S_T);
      prt_u.send(S_R);
    end
    else
      rq.push_back(S_I);
    prt_u.send(S_I);
    prt_u.send(S_I);
    prt_u.quiet();
    repeat (6) @(posedge pclk);
    check(rq.size(), 0, "rxq");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h025E));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 32'hFFFF_FFFF, 32'h0000_01E1);
    rd(12'h000, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(32'(er_q), 32'h1, "unmapped");
    $display("test registers done");
    squelch_pin <= 1'b1;
    wt(crs, 1'b1, 12);
    squelch_pin <= 1'b0;
    soi_detect <= 1'b1;
    @(posedge pclk);
    soi_detect <= 1'b0;
    wt(crs, 1'b0, 2);
    tx_en <= 1'b1;
    @(posedge pclk);
    tx_en <= 1'b0;
    wt(tx_soi, 1'b1, 4);
    nlp_seen <= 1'b1;
    @(posedge pclk);
    nlp_seen <= 1'b0;
    wt(link_pass, 1'b1, 4);
    $display("test ten done");
    apb(1'b1, 12'h000, 32'h8);
    descr_locked <= 1'b1;
    tx_en <= 1'b1;
    stx(5'h0E, S_J);
    stx(5'h0E, S_K);
    repeat (3)
    begin
      d = 5'($urandom);
      stx(d, d);
    end
    @(posedge pclk);
    tx_en <= 1'b0;
    stx(5'h00, S_T);
    stx(5'h00, S_R);
    stx(5'h00, S_I);
    pkt(4, 1'b1);
    $display("test hundred done");
    apb(1'b1, 12'h00C, 32'h30);
    prt_u.send(5'h15);
    prt_u.send(S_J);
    prt_u.send(S_K);
    prt_u.quiet();
    @(negedge pclk);
    check(32'({rx_out.dv, rx_out.false_carrier}), 32'h1, "false");
    rd(12'h00C, 32'h10, 32'h10);
    pkt(2, 1'b0);
    rd(12'h00C, 32'h20, 32'h20);
    $display("test delimiter faults done");
    apb(1'b1, 12'h000, 32'h3);
    wt(tx_halt, 1'b1, 3);
    wt(tx_halt, 1'b0, 40);
    prt_u.flp(16'h0121);
    wt(flp_tx_en, 1'b1, 8);
    check(32'(flp_tx_word), 32'h1E1, "adv");
    repeat (8) @(posedge pclk);
    check(32'({speed100, full_duplex}), 32'h3, "mode");
    rd(12'h008, 32'hFFFF, 32'h0121);
    rd(12'h00C, 32'h8, 32'h8);
    apb(1'b1, 12'h000, 32'h1);
    repeat (4) @(posedge pclk);
    check(32'({speed100, full_duplex}), 32'h0, "forced");
    $display("test negotiation done");
    summarize();
  end
endmodule // pdn_top_tb_top
